/* File: hdl/psm_pkg.sv */
// Package of constants and types for the processor state and mode control
package psm_pkg;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned STAT_W = 32;
  localparam logic [31:0] RESET_VECTOR = 32'ha0000000;
  localparam int unsigned MODE_BIT_POS = 30;
  localparam logic [31:0] STATUS_RESET = 32'h700000f0;
  localparam logic [31:0] VBR_RESET = 32'h00000000;
  localparam logic [31:0] FETCH_STEP = 32'h00000002;
  localparam logic [31:0] PC_RESET = 32'h00000000;
  localparam logic [31:0] SAVE_RESET = 32'h00000000;
  localparam logic [1:0] PD_SLEEP = 2'h0;
  localparam logic [1:0] PD_STANDBY = 2'h1;
  localparam logic [1:0] PD_HW_STANDBY = 2'h2;
  localparam logic [1:0] PD_NONE = 2'h3;

  typedef enum logic [4:0] {
    ST_RESET = 5'h01,
    ST_EXCEPTION = 5'h02,
    ST_EXECUTE = 5'h04,
    ST_POWER_DOWN = 5'h08,
    ST_BUS_RELEASED = 5'h10
  } proc_state_t;

  typedef enum logic [1:0] {
    EXC_NONE = 2'h0,
    EXC_RESET = 2'h1,
    EXC_GENERAL = 2'h2
  } exc_kind_t;
endpackage : psm_pkg

/* File: hdl/psm_ctx_if.sv */
// Interface carrying context save requests to the context store
`timescale 1ns/1ps
interface psm_ctx_if;
  logic save;
  logic [31:0] pc_in;
  logic [31:0] status_in;
  logic [31:0] saved_pc;
  logic [31:0] saved_status;
  modport ctl (output save, output pc_in, output status_in,
               input saved_pc, input saved_status);
  modport store (input save, input pc_in, input status_in,
                 output saved_pc, output saved_status);
endinterface : psm_ctx_if

/* File: hdl/psm_ctx_store.sv */
// Saved program counter and saved status register pair
`timescale 1ns/1ps
module psm_ctx_store (
  input wire logic core_clk,
  input wire logic init,
  psm_ctx_if.store ctx
);
  import psm_pkg::*;
  logic [31:0] ipsave_q, ipsave_d, stsave_q, stsave_d;

  // Capture context on save; cleared on any CPU reset
  always_comb begin
    ipsave_d = ipsave_q;
    stsave_d = stsave_q;
    if (init) begin
      ipsave_d = SAVE_RESET;
      stsave_d = SAVE_RESET;
    end else if (ctx.save) begin
      ipsave_d = ctx.pc_in;
      stsave_d = ctx.status_in;
    end
  end

  always_ff @(posedge core_clk) begin
    ipsave_q <= ipsave_d;
    stsave_q <= stsave_d;
  end

  assign ctx.saved_pc = ipsave_q;
  assign ctx.saved_status = stsave_q;
endmodule // psm_ctx_store

/* File: hdl/psm_bsc_keep.sv */
// External bus controller settings, kept through manual reset
`timescale 1ns/1ps
module psm_busctl_keep #(
  parameter int unsigned CFG_W = 16
) (
  input wire logic core_clk,
  input wire logic por,
  input wire logic cfg_we,
  input wire logic [CFG_W-1:0] cfg_wdata,
  output logic [CFG_W-1:0] cfg_q
);
  logic [CFG_W-1:0] cfg_d;

  // Only power-on reset clears; refresh settings survive manual reset
  always_comb begin
    cfg_d = cfg_q;
    if (por) begin
      cfg_d = '0;
    end else if (cfg_we) begin
      cfg_d = cfg_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    cfg_q <= cfg_d;
  end
endmodule // psm_busctl_keep

/* File: hdl/processor_state_mode_control.sv */
// Processor state, reset kind and privilege mode controller
`timescale 1ns/1ps
// Summary of operation
// - Low reset pin enters reset; bus request high means power-on else manual.
// - Power-on reset initializes CPU state and all module registers.
// - Manual reset initializes all but the bus controller settings.
// - Leaving reset loads the program counter with the reset vector.
// - Exceptions and interrupts save program counter and status word.
// - Then the program counter becomes vector base plus vector offset.
// - Exception handling is transient and passes on to execution.
// - In execution instructions are fetched one after another.
// - Sleep instruction or hardware standby pin enters power-down.
// - Power-down has sleep, standby and hardware standby modes.
// - A bus request releases the bus until it is handed back.
// - The mode bit selects user mode at 0 and privileged mode at 1.
// - Entering reset or exception handling sets the mode bit.
// - Returning from an exception (exc_return) clears the mode bit.
// - Privileged registers are only accessible in privileged mode.
module processor_state_mode_control #(
  parameter int unsigned CFG_W = 16
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic bus_request_pin,
  input wire logic hardware_standby_pin,
  input wire logic sleep_exec,
  input wire logic standby_select,
  input wire logic exc_req,
  input wire logic [31:0] exc_offset,
  input wire logic exc_return,
  input wire logic wakeup,
  input wire logic priv_access,
  input wire logic vbr_we,
  input wire logic [31:0] vbr_wdata,
  input wire logic busctl_we,
  input wire logic [CFG_W-1:0] busctl_wdata,
  output psm_pkg::proc_state_t state,
  output logic [31:0] instruction_pointer,
  output logic [31:0] status_word,
  output logic [31:0] saved_pc_register,
  output logic [31:0] saved_status_register,
  output logic privilege_mode_bit,
  output logic [1:0] power_down_mode,
  output logic bus_grant,
  output logic last_reset_por,
  output logic priv_violation,
  output logic [CFG_W-1:0] busctl_cfg
);
  import psm_pkg::*;

  // Controller state
  proc_state_t st_q;
  proc_state_t st_d;
  // Program counter
  logic [31:0] ip_q;
  logic [31:0] ip_d;
  // Status word holding the privilege mode bit
  logic [31:0] stat_q;
  logic [31:0] stat_d;
  // Vector base
  logic [31:0] vbase_q;
  logic [31:0] vbase_d;
  // Power-down mode
  logic [1:0] pdm_q;
  logic [1:0] pdm_d;
  // Bus grant towards the requesting master
  logic gnt_q;
  logic gnt_d;
  // Kind of the last reset
  logic por_kind_q;
  logic por_kind_d;
  // One-cycle privilege violation pulse
  logic viol_q;
  logic viol_d;
  // Reset decode
  logic in_reset;
  logic por_now;
  logic init;
  // Events taken in execute, highest priority first
  logic in_exec;
  logic go_bus;
  logic go_exc;
  logic go_hws;
  logic go_sleep;
  logic go_ret;
  logic go_fetch;
  // Mode, wake and vector decode
  logic user_mode;
  logic wake_ok;
  logic [31:0] vec_target;
  // Context read back from the store
  logic [31:0] saved_ip_w;
  logic [31:0] saved_stat_w;

  psm_ctx_if ctx ();

  // Reset kind decode from the bus request pin
  assign in_reset = !resetn;
  assign por_now = in_reset && bus_request_pin;
  assign init = in_reset;

  // Execute-state events; only one is taken per cycle
  assign in_exec = st_q == ST_EXECUTE;
  assign go_bus = in_exec && bus_request_pin;
  assign go_exc = in_exec && !bus_request_pin && exc_req;
  assign go_hws = in_exec && !bus_request_pin && !exc_req &&
    hardware_standby_pin;
  assign go_sleep = in_exec && !bus_request_pin && !exc_req &&
    !hardware_standby_pin && sleep_exec;
  assign go_ret = in_exec && !bus_request_pin && !exc_req &&
    !hardware_standby_pin && !sleep_exec && exc_return;
  assign go_fetch = in_exec && !bus_request_pin && !exc_req &&
    !hardware_standby_pin && !sleep_exec && !exc_return;

  // Privilege level, wake condition and vector target
  assign user_mode = !stat_q[MODE_BIT_POS];
  assign wake_ok = (pdm_q == PD_HW_STANDBY) ? !hardware_standby_pin :
    (wakeup || exc_req);
  assign vec_target = vbase_q + exc_offset;

  // Saved program counter and status pair
  psm_ctx_store u_ctx (
    .core_clk(core_clk),
    .init(init),
    .ctx(ctx)
  );

  // Bus controller settings, cleared by power-on reset only
  psm_busctl_keep #(.CFG_W(CFG_W)) u_busctl (
    .core_clk(core_clk),
    .por(por_now),
    .cfg_we(busctl_we && !in_reset),
    .cfg_wdata(busctl_wdata),
    .cfg_q(busctl_cfg)
  );

  // Context save request towards the store
  assign ctx.save = go_exc;
  assign ctx.pc_in = ip_q;
  assign ctx.status_in = stat_q;
  assign saved_ip_w = ctx.saved_pc;
  assign saved_stat_w = ctx.saved_status;

  // Next processor state
  always_comb begin
    st_d = st_q;
    if (in_reset) begin
      st_d = ST_RESET;
    end else begin
      unique case (st_q)
        ST_RESET: begin
          st_d = ST_EXCEPTION;
        end
        ST_EXCEPTION: begin
          st_d = ST_EXECUTE;
        end
        ST_EXECUTE: begin
          if (go_bus) begin
            st_d = ST_BUS_RELEASED;
          end else if (go_exc) begin
            st_d = ST_EXCEPTION;
          end else if (go_hws || go_sleep) begin
            st_d = ST_POWER_DOWN;
          end
        end
        ST_POWER_DOWN: begin
          if (wake_ok) begin
            st_d = ST_EXECUTE;
          end
        end
        ST_BUS_RELEASED: begin
          if (!bus_request_pin) begin
            st_d = ST_EXECUTE;
          end
        end
        default: begin
          st_d = ST_RESET;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    st_q <= st_d;
  end

  // Program counter: reset vector, exception vector, return or sequential fetch
  always_comb begin
    ip_d = ip_q;
    if (in_reset) begin
      ip_d = PC_RESET;
    end else if (st_q == ST_RESET) begin
      ip_d = RESET_VECTOR;
    end else if (go_exc) begin
      ip_d = vec_target;
    end else if (go_ret) begin
      ip_d = saved_ip_w;
    end else if (go_fetch) begin
      ip_d = ip_q + FETCH_STEP;
    end
  end

  // Program counter register
  always_ff @(posedge core_clk) begin
    ip_q <= ip_d;
  end

  // Status word: mode set on reset and exception, cleared on return
  always_comb begin
    stat_d = stat_q;
    if (in_reset) begin
      stat_d = STATUS_RESET;
      stat_d[MODE_BIT_POS] = 1'b1;
    end else if (st_q == ST_RESET || go_exc) begin
      stat_d[MODE_BIT_POS] = 1'b1;
    end else if (go_ret) begin
      stat_d = saved_stat_w;
      stat_d[MODE_BIT_POS] = 1'b0;
    end
  end

  // Status word register
  always_ff @(posedge core_clk) begin
    stat_q <= stat_d;
  end

  // Vector base, writable in privileged mode only
  always_comb begin
    vbase_d = vbase_q;
    if (in_reset) begin
      vbase_d = VBR_RESET;
    end else if (in_exec && vbr_we && !user_mode) begin
      vbase_d = vbr_wdata;
    end
  end

  // Vector base register
  always_ff @(posedge core_clk) begin
    vbase_q <= vbase_d;
  end

  // Power-down mode select and release
  always_comb begin
    pdm_d = pdm_q;
    if (in_reset) begin
      pdm_d = PD_NONE;
    end else if (go_hws) begin
      pdm_d = PD_HW_STANDBY;
    end else if (go_sleep) begin
      pdm_d = standby_select ? PD_STANDBY : PD_SLEEP;
    end else if (st_q == ST_POWER_DOWN && wake_ok) begin
      pdm_d = PD_NONE;
    end
  end

  // Power-down mode register
  always_ff @(posedge core_clk) begin
    pdm_q <= pdm_d;
  end

  // Grant held while the master keeps its request up
  always_comb begin
    gnt_d = 1'b0;
    if (!in_reset) begin
      if (go_bus) begin
        gnt_d = 1'b1;
      end else if (st_q == ST_BUS_RELEASED) begin
        gnt_d = bus_request_pin;
      end
    end
  end

  // Bus grant register
  always_ff @(posedge core_clk) begin
    gnt_q <= gnt_d;
  end

  // Reset kind, taken from the request pin during reset
  always_comb begin
    por_kind_d = por_kind_q;
    if (in_reset) begin
      por_kind_d = bus_request_pin;
    end
  end

  // Reset kind register
  always_ff @(posedge core_clk) begin
    por_kind_q <= por_kind_d;
  end

  // Privileged access attempted from user mode
  always_comb begin
    viol_d = 1'b0;
    if (!in_reset && in_exec && user_mode) begin
      if (vbr_we || priv_access) begin
        viol_d = 1'b1;
      end
    end
  end

  // Violation pulse register
  always_ff @(posedge core_clk) begin
    viol_q <= viol_d;
  end

  // Outputs straight from flip-flops
  assign state = st_q;
  assign instruction_pointer = ip_q;
  assign status_word = stat_q;
  assign privilege_mode_bit = stat_q[MODE_BIT_POS];
  assign power_down_mode = pdm_q;
  assign bus_grant = gnt_q;
  assign last_reset_por = por_kind_q;
  assign priv_violation = viol_q;
  assign saved_pc_register = saved_ip_w;
  assign saved_status_register = saved_stat_w;
endmodule // processor_state_mode_control

/* File: tb/psm_partner.sv */
// Reset source and external bus master model
`timescale 1ns/1ps
module psm_partner (
  input wire logic core_clk,
  input wire logic bus_grant,
  output logic resetn,
  output logic bus_request_pin
);
  // Power-on reset from time zero
  initial begin
    resetn = 1'b0;
    bus_request_pin = 1'b1;
  end
  // Reset of the kind chosen by the request pin
  task reset_seq(input logic por);
    @(negedge core_clk);
    resetn = 1'b0;
    bus_request_pin = por;
    repeat (16) @(negedge core_clk);
    resetn = 1'b1;
    bus_request_pin = 1'b0;
  endtask
  // Request held until granted, bus handed back n cycles later
  task take_bus(input int n);
    int w;
    @(negedge core_clk);
    bus_request_pin = 1'b1;
    for (w = 0; w < 20 && bus_grant !== 1'b1; w++) @(negedge core_clk);
    repeat (n) @(negedge core_clk);
    bus_request_pin = 1'b0;
  endtask
endmodule // psm_partner

/* File: tb/psm_sva.sv */
// Port checker for the processor state and mode controller
`timescale 1ns/1ps
module psm_sva (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic bus_request_pin,
  input wire logic hardware_standby_pin,
  input wire logic sleep_exec,
  input wire logic exc_req,
  input wire logic exc_return,
  input wire logic vbr_we,
  input wire psm_pkg::proc_state_t state,
  input wire logic [31:0] instruction_pointer,
  input wire logic [31:0] status_word,
  input wire logic [31:0] saved_pc_register,
  input wire logic [31:0] saved_status_register,
  input wire logic privilege_mode_bit,
  input wire logic bus_grant,
  input wire logic last_reset_por,
  input wire logic priv_violation
);
  import psm_pkg::*;
  logic run;
  // Execute state with no event pending
  assign run = state == ST_EXECUTE && !(bus_request_pin | exc_req |
    hardware_standby_pin | sleep_exec | exc_return);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  AST_RST_ENTRY: assert property ($rose(resetn) |->
    state == ST_RESET && privilege_mode_bit && !bus_grant)
    else $error("reset state not entered");
  AST_RST_KIND: assert property ($rose(resetn) |->
    last_reset_por == $past(bus_request_pin))
    else $error("reset kind not recorded");
  AST_RST_VECTOR: assert property ($rose(resetn) |=>
    state == ST_EXCEPTION && instruction_pointer == RESET_VECTOR)
    else $error("reset vector not loaded");
  AST_EXC_SAVE: assert property (state == ST_EXECUTE && exc_req &&
    !bus_request_pin |=> state == ST_EXCEPTION && privilege_mode_bit &&
    saved_pc_register == $past(instruction_pointer) &&
    saved_status_register == $past(status_word))
    else $error("context not saved");
  AST_TRANSIENT: assert property (state == ST_EXCEPTION |=>
    state == ST_EXECUTE) else $error("exception state not transient");
  AST_FETCH: assert property (run |=> instruction_pointer ==
    $past(instruction_pointer) + FETCH_STEP) else $error("fetch step wrong");
  AST_MODE_BIT: assert property (
    privilege_mode_bit == status_word[MODE_BIT_POS])
    else $error("mode bit differs from status word");
  AST_BUS: assert property (bus_request_pin && (state == ST_EXECUTE ||
    state == ST_BUS_RELEASED) |=> state == ST_BUS_RELEASED && bus_grant)
    else $error("bus not released");
  AST_PRIV: assert property (state == ST_EXECUTE && vbr_we &&
    !privilege_mode_bit && !bus_request_pin |=> priv_violation)
    else $error("user write not flagged");
endmodule // psm_sva
bind processor_state_mode_control psm_sva sva (.core_clk, .resetn,
  .bus_request_pin, .hardware_standby_pin, .sleep_exec, .exc_req, .exc_return,
  .vbr_we, .state, .instruction_pointer, .status_word, .saved_pc_register,
  .saved_status_register, .privilege_mode_bit, .bus_grant, .last_reset_por,
  .priv_violation);

/* File: tb/testbench.sv */
// Self-checking bench for the processor state and mode controller
`timescale 1ns/1ps
module testbench;
  import psm_pkg::*;
  logic core_clk = 0, resetn, bus_request_pin, hardware_standby_pin = 0;
  logic sleep_exec = 0, standby_select = 0, exc_req = 0, exc_return = 0;
  logic wakeup = 0, priv_access = 0, vbr_we = 0, busctl_we = 0;
  logic [31:0] exc_offset = '0, vbr_wdata = '0, ip, sw, sv_ip, sv_st;
  logic [15:0] busctl_wdata = '0, cfg;
  logic mode_bit, grant, lpor, viol;
  logic [1:0] pdm;
  proc_state_t state;
  int errors = 0, n_checks = 0;
  psm_partner p (.core_clk, .bus_grant(grant), .resetn, .bus_request_pin);
  processor_state_mode_control dut (.core_clk, .resetn, .bus_request_pin,
    .hardware_standby_pin, .sleep_exec, .standby_select, .exc_req, .exc_offset,
    .exc_return, .wakeup, .priv_access, .vbr_we, .vbr_wdata, .busctl_we,
    .busctl_wdata, .state, .instruction_pointer(ip), .status_word(sw),
    .saved_pc_register(sv_ip), .saved_status_register(sv_st),
    .privilege_mode_bit(mode_bit), .power_down_mode(pdm), .bus_grant(grant),
    .last_reset_por(lpor), .priv_violation(viol), .busctl_cfg(cfg));
  // Clock of 5 ns
  initial forever #2.5 core_clk = ~core_clk;
  task nc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %0t %h %h", $time, g, e);
    end
  endtask
  task end_of_test;
    if (errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task t_reset(input logic por);
    p.reset_seq(por);
    nc(1);
    chk(state, ST_EXCEPTION);
    chk(ip, RESET_VECTOR);
    chk(lpor, por);
    nc(1);
    chk(state, ST_EXECUTE);
  endtask
  task t_exc;
    logic [31:0] pc0, sw0;
    vbr_we = 1;
    vbr_wdata = 32'h00000100;
    nc(1);
    vbr_we = 0;
    exc_req = 1;
    exc_offset = 32'h00000040;
    pc0 = ip;
    sw0 = sw;
    nc(1);
    exc_req = 0;
    chk(ip, 32'h00000140);
    chk(sv_ip, pc0);
    chk(sv_st, sw0);
    nc(1);
    exc_return = 1;
    nc(1);
    exc_return = 0;
    chk(mode_bit, 1'b0);
    chk(sw, STATUS_RESET & ~32'h40000000);
    priv_access = 1;
    nc(1);
    priv_access = 0;
    chk(viol, 1'b1);
    nc(1);
    chk(viol, 1'b0);
    vbr_we = 1;
    vbr_wdata = 32'h00000200;
    nc(1);
    vbr_we = 0;
    chk(viol, 1'b1);
    exc_req = 1;
    nc(1);
    exc_req = 0;
    chk(ip, 32'h00000140);
    chk(mode_bit, 1'b1);
  endtask
  task t_bus;
    fork
      p.take_bus(4);
      begin
        nc(2);
        chk(grant, 1'b1);
        chk(state, ST_BUS_RELEASED);
      end
    join
    nc(1);
    chk(grant, 1'b0);
    chk(state, ST_EXECUTE);
  endtask
  task t_busctl;
    busctl_we = 1;
    busctl_wdata = 16'h5a5a;
    nc(1);
    busctl_we = 0;
    t_reset(1'b0);
    chk(cfg, 16'h5a5a);
    t_reset(1'b1);
    chk(cfg, 16'h0000);
  endtask
  task t_pd;
    for (int m = 0; m < 3; m++) begin
      sleep_exec = m < 2;
      standby_select = m == 1;
      hardware_standby_pin = m == 2;
      nc(1);
      sleep_exec = 0;
      chk(state, ST_POWER_DOWN);
      chk(pdm, m[1:0]);
      if (m < 2) begin
        wakeup = 1;
        nc(1);
        wakeup = 0;
        chk(state, ST_EXECUTE);
      end else begin
        hardware_standby_pin = 0;
        nc(1);
        chk(state, ST_EXECUTE);
        chk(pdm, PD_NONE);
      end
    end
  endtask
  // Main sequence
  initial begin
    t_reset(1'b1);
    t_exc;
    t_bus;
    t_busctl;
    t_pd;
    end_of_test;
  end
  // Watchdog
  initial begin
    #20000;
    errors++;
    end_of_test;
  end
endmodule // testbench
